// ==== src/ftt_pkg.sv ====
// Constants, types and helpers for the FP truncate-to-fixed unit
// Function
// - Long variant truncates the source to a 64-bit signed integer.
// - Word variant truncates the source to a 32-bit signed integer.
// - Result goes to the destination register unless a trap stops it.
// - Invalid when source is infinity, NaN or truncates out of range.
// - Invalid condition sets the invalid flag in the control register.
// - Invalid with its enable set: no write, exception at once.
// - Invalid with invalid and overflow enables clear writes the largest positive value.
// - Unit signals unusable, reserved, inexact, invalid, overflow, unimpl.
package ftt_pkg;

  // ==========================================================
  // Register map
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_IST    = 4'h4;
  localparam logic [3:0] ADDR_IMASK  = 4'h8;
  localparam logic [3:0] ADDR_RES_LO = 4'hC;
  localparam logic [3:0] ADDR_RES_HI = 4'hD;

  // ==========================================================
  // Control register fields
  localparam int F_INX   = 0;
  localparam int F_OVF   = 1;
  localparam int F_INV   = 2;
  localparam int F_UNIMP = 3;
  localparam int FLAG_LSB  = 0;
  localparam int EN_LSB    = 8;
  localparam int CAUSE_LSB = 16;
  localparam logic [3:0] FLAG_RST = 4'h0;
  localparam logic [3:0] EN_RST   = 4'h0;

  // ==========================================================
  // Interrupt events
  localparam int EV_DONE = 0;
  localparam int EV_INV  = 1;
  localparam int EV_TRAP = 2;
  localparam logic [2:0] IST_RST   = 3'h0;
  localparam logic [2:0] IMASK_RST = 3'h0;

  // ==========================================================
  // Source formats and exception codes
  localparam logic [4:0] FMT_S = 5'h00;
  localparam logic [4:0] FMT_D = 5'h01;
  localparam logic [2:0] EXC_NONE = 3'h0;
  localparam logic [2:0] EXC_CPU  = 3'h1;
  localparam logic [2:0] EXC_RI   = 3'h2;
  localparam logic [2:0] EXC_FPE  = 3'h3;

  // ==========================================================
  // Float layout
  localparam logic signed [12:0] BIAS_S = 13'sh007F;
  localparam logic signed [12:0] BIAS_D = 13'sh03FF;
  localparam logic [6:0] LIM_L = 7'h3F;
  localparam logic [6:0] LIM_W = 7'h1F;
  localparam logic [6:0] FIX_SH = 7'h0C;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CALC = 2'b10
  } ftt_state_e;

  // Largest positive value of the target width
  function automatic logic [63:0] ftt_sat_max(input logic is_long);
    ftt_sat_max = is_long ? 64'h7FFFFFFFFFFFFFFF : 64'h000000007FFFFFFF;
  endfunction

endpackage

// ==== src/ftt_trunc_core.sv ====
// Combinational float to fixed conversion, rounding toward zero
`timescale 1ns/1ns
module ftt_trunc_core
  import ftt_pkg::*;
(
  input  wire logic        to_long_i,
  input  wire logic        dbl_i,
  input  wire logic [63:0] opnd_i,
  output logic [63:0]      value_o,
  output logic             invalid_o,
  output logic             overflow_o,
  output logic             inexact_o
);

  logic               sgn;
  logic               nan_inf;
  logic [52:0]        man;
  logic signed [12:0] ue;
  logic [6:0]         lim;
  logic [127:0]       fx;
  logic [63:0]        mag;
  logic [63:0]        edge_v;
  logic               frac;
  logic               big;

  // ==========================================================
  // Field extraction
  // single or double
  always_comb
  begin
    if (dbl_i)
    begin
      sgn     = opnd_i[63];
      nan_inf = &opnd_i[62:52];
      man     = {(opnd_i[62:52] != 11'h000), opnd_i[51:0]};
      ue      = $signed({2'h0, opnd_i[62:52]}) - BIAS_D;
    end
    else
    begin
      sgn     = opnd_i[31];
      nan_inf = &opnd_i[30:23];
      man     = {(opnd_i[30:23] != 8'h00), opnd_i[22:0], 29'h0};
      ue      = $signed({5'h00, opnd_i[30:23]}) - BIAS_S;
    end
  end

  // ==========================================================
  // Truncation and range check
  always_comb
  begin
    lim    = to_long_i ? LIM_L : LIM_W;
    edge_v = 64'h1 << lim;
    fx     = 128'h0;
    mag    = 64'h0;
    frac   = 1'b0;
    big    = 1'b0;
    if (ue < 0)
      frac = |man;
    else if (ue > $signed({6'h00, lim}))
      big = 1'b1;
    else
    begin
      // Value times 2^64: integer part high, fraction low
      fx   = {75'h0, man} << (ue[6:0] + FIX_SH);
      mag  = fx[127:64];
      frac = |fx[63:0];
      // only the negative edge value fits
      big  = (mag >= edge_v) && !(sgn && mag == edge_v);
    end
  end

  // ==========================================================
  // Result and conditions
  always_comb
  begin
    invalid_o  = nan_inf || big;
    overflow_o = big && !nan_inf;
    inexact_o  = frac && !invalid_o;
    if (invalid_o)
      value_o = ftt_sat_max(to_long_i);
    else if (to_long_i)
      value_o = sgn ? 64'(-mag) : mag;
    else
      value_o = {32'h0, sgn ? 32'(-mag[31:0]) : mag[31:0]};
  end

endmodule

// ==== src/ftt_unit.sv ====
// FP truncate-to-fixed unit with register file and control registers
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ns
module ftt_unit
  import ftt_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        op_valid_i,
  input  wire logic        op_long_i,
  input  wire logic [4:0]  op_fmt_i,
  input  wire logic [4:0]  source_fp_reg_i,
  input  wire logic [4:0]  dest_fp_reg_i,
  input  wire logic        cop_usable_i,
  input  wire logic        fr64_mode_i,
  input  wire logic        rf_load_i,
  input  wire logic [4:0]  rf_load_idx_i,
  input  wire logic [63:0] rf_load_data_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic [31:0]      reg_rdata_o,
  output logic             busy_o,
  output logic             done_o,
  output logic             exc_o,
  output logic [2:0]       exc_code_o,
  output logic [63:0]      result_o,
  output logic             irq_o
);

  ftt_state_e  state;
  ftt_state_e  next_state;
  logic [63:0] fp_register [32];
  logic [63:0] opnd_q;
  logic        long_q;
  logic        dbl_q;
  logic [4:0]  dst_q;
  logic        cu_bad_q;
  logic        ri_q;
  logic        unimp_q;
  logic [3:0]  flags;
  logic [3:0]  en;
  logic [3:0]  cause;
  logic [2:0]  ist;
  logic [2:0]  imask;
  logic [63:0] core_val;
  logic        core_inv;
  logic        core_ovf;
  logic        core_inx;
  logic        accept;
  logic        calc;
  logic [3:0]  next_cause;
  logic        trap;
  logic        do_wr;
  logic [2:0]  next_code;
  logic [2:0]  ev;
  logic        wr_ctrl;
  logic        wr_ist;
  logic        wr_imask;

  ftt_trunc_core u_core (
    .to_long_i  (long_q),
    .dbl_i      (dbl_q),
    .opnd_i     (opnd_q),
    .value_o    (core_val),
    .invalid_o  (core_inv),
    .overflow_o (core_ovf),
    .inexact_o  (core_inx)
  );

  // ==========================================================
  // Issue and sequencing
  assign accept = (state == ST_IDLE) && op_valid_i;
  assign calc   = (state == ST_CALC);

  always_comb
  begin
    case (state)
      ST_IDLE: next_state = op_valid_i ? ST_CALC : ST_IDLE;
      ST_CALC: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state  <= ST_IDLE;
      busy_o <= 1'b0;
    end
    else
    begin
      state  <= next_state;
      busy_o <= (next_state == ST_CALC);
    end
  end

  // Operand capture at issue
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      opnd_q   <= 64'h0;
      long_q   <= 1'b0;
      dbl_q    <= 1'b0;
      dst_q    <= 5'h00;
      cu_bad_q <= 1'b0;
      ri_q     <= 1'b0;
      unimp_q  <= 1'b0;
    end
    else if (accept)
    begin
      opnd_q   <= fp_register[source_fp_reg_i];
      long_q   <= op_long_i;
      dbl_q    <= (op_fmt_i == FMT_D);
      dst_q    <= dest_fp_reg_i;
      cu_bad_q <= !cop_usable_i;
      ri_q     <= (op_fmt_i != FMT_S) && (op_fmt_i != FMT_D);
      // Long form needs the 32-register mode
      unimp_q  <= op_long_i && !fr64_mode_i;
    end
  end

  // ==========================================================
  // Exception decision
  always_comb
  begin
    next_cause = 4'h0;
    next_code  = EXC_NONE;
    if (!cu_bad_q && !ri_q)
    begin
      next_cause[F_UNIMP] = unimp_q;
      if (!unimp_q)
      begin
        next_cause[F_INV] = core_inv;
        next_cause[F_OVF] = core_ovf;
        next_cause[F_INX] = core_inx;
      end
    end
    if (cu_bad_q)
      next_code = EXC_CPU;
    else if (ri_q)
      next_code = EXC_RI;
    else if (unimp_q || |(next_cause & en))
      next_code = EXC_FPE;
    trap  = (next_code != EXC_NONE);
    do_wr = calc && !trap;
  end

  // ==========================================================
  // Register file: writeback wins over a load
  always_ff @(posedge clk_i)
  begin
    if (do_wr)
      fp_register[dst_q] <= core_val;
    else if (rf_load_i)
      fp_register[rf_load_idx_i] <= rf_load_data_i;
  end

  // Completion outputs
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      done_o     <= 1'b0;
      exc_o      <= 1'b0;
      exc_code_o <= EXC_NONE;
      result_o   <= 64'h0;
    end
    else
    begin
      done_o     <= calc;
      exc_o      <= calc && trap;
      exc_code_o <= calc ? next_code : EXC_NONE;
      if (calc)
        result_o <= core_val;
    end
  end

  // ==========================================================
  // Control and status register
  assign wr_ctrl  = reg_we_i && (reg_addr_i == ADDR_CTRL);
  assign wr_ist   = reg_we_i && (reg_addr_i == ADDR_IST);
  assign wr_imask = reg_we_i && (reg_addr_i == ADDR_IMASK);

  // Sticky flags: hardware set wins over a write
  // inexact, overflow, invalid and unimplemented flags
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      flags <= FLAG_RST;
    else
      flags <= (wr_ctrl ? reg_wdata_i[FLAG_LSB +: 4] : flags)
               | (calc ? next_cause : 4'h0);
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      en <= EN_RST;
    else if (wr_ctrl)
      en <= reg_wdata_i[EN_LSB +: 4];
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cause <= 4'h0;
    else if (calc)
      cause <= next_cause;
  end

  // ==========================================================
  // Interrupts
  assign ev = calc ? {trap, next_cause[F_INV], 1'b1} : 3'h0;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ist <= IST_RST;
    else
      ist <= (ist & ~(wr_ist ? reg_wdata_i[2:0] : 3'h0)) | ev;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      imask <= IMASK_RST;
    else if (wr_imask)
      imask <= reg_wdata_i[2:0];
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(ist & imask);
  end

  // ==========================================================
  // Read port
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      reg_rdata_o <= 32'h0;
    else if (!reg_re_i)
      reg_rdata_o <= 32'h0;
    else
      case (reg_addr_i)
        ADDR_CTRL:   reg_rdata_o <= {12'h0, cause, 4'h0, en,
                                     4'h0, flags};
        ADDR_IST:    reg_rdata_o <= {29'h0, ist};
        ADDR_IMASK:  reg_rdata_o <= {29'h0, imask};
        ADDR_RES_LO: reg_rdata_o <= result_o[31:0];
        ADDR_RES_HI: reg_rdata_o <= result_o[63:32];
        default:     reg_rdata_o <= 32'h0;
      endcase
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  issue_done_a: assert property (
    accept |-> ##2 done_o && !busy_o)
    else $error("done not two cycles after issue");

  word_range_a: assert property (
    done_o && !exc_o && !$past(long_q) |-> result_o[63:32] == 32'h0)
    else $error("word result not in low word");

  wb_value_a: assert property (
    done_o && !exc_o |-> fp_register[$past(dst_q)] == result_o)
    else $error("result not in destination register");

  inf_inv_a: assert property (
    calc && dbl_q && (&opnd_q[62:52]) && !cu_bad_q && !ri_q && !unimp_q
    |=> cause[F_INV] && !cause[F_OVF])
    else $error("infinity or NaN not invalid");

  inv_flag_a: assert property (
    calc && next_cause[F_INV] |=> flags[F_INV] && cause[F_INV])
    else $error("invalid flag not set");

  trap_nowr_a: assert property (
    calc && core_inv && en[F_INV] && !cu_bad_q && !ri_q
    |-> !do_wr ##1 exc_o && exc_code_o == EXC_FPE)
    else $error("enabled invalid did not trap");

  sat_val_a: assert property (
    calc && core_inv && !trap
    |=> result_o == ftt_sat_max($past(long_q)))
    else $error("default result not saturated");

  ri_fmt_a: assert property (
    accept && cop_usable_i && op_fmt_i != FMT_S && op_fmt_i != FMT_D
    |-> ##2 exc_o && exc_code_o == EXC_RI)
    else $error("bad format not reserved");

  cpu_exc_a: assert property (
    accept && !cop_usable_i |-> ##2 exc_code_o == EXC_CPU)
    else $error("unusable exception missing");

  inx_flag_a: assert property (
    calc && core_inx && !trap |=> flags[F_INX] && !exc_o)
    else $error("inexact flag not set");

  irq_lvl_a: assert property (
    (|(ist & imask)) |=> irq_o)
    else $error("irq not raised");

  long_cov: cover property (accept && op_long_i ##2 done_o && !exc_o);
  word_cov: cover property (accept && !op_long_i ##2 done_o && !exc_o);
  sat_cov:  cover property (calc && core_inv && !trap);
  trap_cov: cover property (done_o && exc_code_o == EXC_FPE);

endmodule

// ==== testbench/ftt_issue_model.sv ====
// Pipeline-side model that issues conversions to the unit
`timescale 1ns/1ns
module ftt_issue_model
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        go_i,
  input  wire logic [15:0] fld_i,
  output logic             op_valid_o,
  output logic [15:0]      fld_o
);
  // ======================================
  // Issue stage
  // bench picks the fields
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      op_valid_o <= 1'b0;
      fld_o      <= 16'h0000;
    end
    else
    begin
      op_valid_o <= go_i;
      fld_o      <= go_i ? fld_i : ~fld_o;
    end
  end
endmodule

// ==== testbench/test_ftt_unit.sv ====
// Self-checking bench for the truncate-to-fixed unit
`timescale 1ns/1ns
module test_ftt_unit
  import ftt_pkg::*;
;
  logic        clk_i, rstn_i, go, op_valid, rf_load, reg_we, reg_re;
  logic        cop, fr, busy, done, exc, irq;
  logic [15:0] fld, fld_q;
  logic [4:0]  rf_load_idx;
  logic [63:0] rf_load_data, result;
  logic [3:0]  reg_addr, flags, en, cause;
  logic [31:0] reg_wdata, reg_rdata;
  logic [2:0]  exc_code, ist, imask;
  logic [63:0] rf [32];
  int          n_mismatch, tests_run;
  logic [3:0]  adr [6] = '{ADDR_CTRL, ADDR_IST, ADDR_IMASK, ADDR_RES_LO,
                           4'h2, ADDR_RES_HI};
  logic [64:0] tab [14] = '{
    65'h1_43E0000000000000, 65'h1_C3E0000000000000, 65'h1_41E0000000000000,
    65'h1_C1E0000000000000, 65'h1_41DFFFFFFFE00000, 65'h1_7FF0000000000000,
    65'h1_7FF8000000000000, 65'h1_BFF8000000000000, 65'h1_0000000000000001,
    65'h1_8000000000000000, 65'h0_00000000CF000000, 65'h0_000000005F000000,
    65'h0_000000007F800000, 65'h0_000000003FC00000};

  ftt_issue_model u_issue (.clk_i(clk_i), .rstn_i(rstn_i), .go_i(go),
    .fld_i(fld), .op_valid_o(op_valid), .fld_o(fld_q));

  ftt_unit DUT (.clk_i(clk_i), .rstn_i(rstn_i), .op_valid_i(op_valid),
    .op_long_i(fld_q[15]), .op_fmt_i(fld_q[14:10]),
    .source_fp_reg_i(fld_q[9:5]), .dest_fp_reg_i(fld_q[4:0]),
    .cop_usable_i(cop), .fr64_mode_i(fr), .rf_load_i(rf_load),
    .rf_load_idx_i(rf_load_idx), .rf_load_data_i(rf_load_data),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_we_i(reg_we),
    .reg_re_i(reg_re), .reg_rdata_o(reg_rdata), .busy_o(busy),
    .done_o(done), .exc_o(exc), .exc_code_o(exc_code),
    .result_o(result), .irq_o(irq));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ======================================
  // Shared tasks
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Compares %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_i);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_i);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic load(input logic [4:0] i, input logic [63:0] v);
    @(posedge clk_i);
    rf_load      <= 1'b1;
    rf_load_idx  <= i;
    rf_load_data <= v;
    @(posedge clk_i);
    rf_load <= 1'b0;
    rf[i] = v;
  endtask

  // ======================================
  // Reference truncation toward zero
  function automatic void ref_cvt(input logic lng, input logic dbl,
    input logic [63:0] b, output logic [63:0] r, output logic [3:0] fl);
    int           e;
    logic [127:0] m;
    logic         s;
    logic         inx;
    s   = dbl ? b[63] : b[31];
    e   = dbl ? int'(b[62:52]) : int'(b[30:23]);
    m   = dbl ? {75'h0, 1'b1, b[51:0]} : {104'h0, 1'b1, b[22:0]};
    inx = 1'b0;
    fl  = (e == (dbl ? 2047 : 255)) ? 4'h4 : 4'h0;
    if (e == 0)
    begin
      inx = dbl ? |b[51:0] : |b[22:0];
      m   = 128'h0;
    end
    else if (!fl[2])
    begin
      e = e - (dbl ? 1075 : 150);
      if (e > 64)
        m = 128'h1 << 100;
      else if (e >= 0)
        m = m << e;
      else
      begin
        inx = (m & ~('1 << -e)) != 0;
        m   = m >> -e;
      end
    end
    if (!fl[2] && m + (s ? 0 : 1) > (128'h1 << (lng ? 63 : 31)))
      fl = 4'h6;
    if (fl != 4'h0)
      r = lng ? 64'h7FFFFFFFFFFFFFFF : 64'h000000007FFFFFFF;
    else
    begin
      r  = s ? -m[63:0] : m[63:0];
      r  = lng ? r : {32'h0, r[31:0]};
      fl = {3'h0, inx};
    end
  endfunction

  // ======================================
  // Main sequence
  initial
  begin
    logic [63:0] v, r;
    logic [31:0] d;
    logic [3:0]  fl;
    logic [2:0]  code, w;
    logic [4:0]  f, s, t;
    logic        lng, dbl, trap, uc, fm;
    {rstn_i, go, rf_load, reg_we, reg_re} = 5'h00;
    {fld, rf_load_idx, reg_addr, reg_wdata, rf_load_data} = '0;
    {cop, fr} = 2'h3;
    {flags, en, cause, ist, imask} = '0;
    n_mismatch = 0;
    tests_run  = 0;
    void'($urandom(15952));
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      if (k > 3)
        wr(adr[k], 32'hFFFFFFFF);
      rd(adr[k], d);
      chk(d, 32'h0);
    end
    chk(irq, 1'b0);
    $display("Test reset values done");
    for (int k = 0; k < 32; k++)
      load(5'(k), {$urandom, $urandom});
    for (int i = 0; i < 148; i++)
    begin
      en    = 4'($urandom) & 4'h7;
      flags = 4'($urandom);
      wr(ADDR_CTRL, {12'h0, 4'hF, 4'h0, en, 4'h0, flags});
      imask = 3'($urandom);
      wr(ADDR_IMASK, {29'h0, imask});
      w = 3'($urandom);
      wr(ADDR_IST, {29'h0, w});
      ist = ist & ~w;
      lng = i[0];
      s   = 5'($urandom);
      t   = 5'($urandom);
      uc  = 1'b1;
      fm  = 1'b1;
      if (i < 28)
        {dbl, v} = tab[i / 2];
      else
      begin
        dbl = 1'($urandom);
        v   = {$urandom, $urandom};
        if (dbl)
          v[62:52] = 11'(1015 + $urandom_range(0, 60));
        else
          v = {32'h0, v[31], 8'(119 + $urandom_range(0, 50)), v[22:0]};
        uc = $urandom_range(0, 15) != 0;
        fm = $urandom_range(0, 15) != 0;
      end
      f = dbl ? FMT_D : FMT_S;
      if (i >= 28 && $urandom_range(0, 15) == 0)
        f = 5'h1F;
      if (i < 28 || $urandom_range(0, 3) != 0)
        load(s, v);
      v = rf[s];
      ref_cvt(lng, f == FMT_D, v, r, fl);
      code = EXC_NONE;
      if (!uc)
        code = EXC_CPU;
      else if (f != FMT_S && f != FMT_D)
        code = EXC_RI;
      else if (lng && !fm)
        fl = 4'h8;
      if (code != EXC_NONE)
        fl = 4'h0;
      else if (fl[3] || (fl & en) != 4'h0)
        code = EXC_FPE;
      trap  = code != EXC_NONE;
      cause = fl;
      flags = flags | fl;
      ist   = ist | {trap, fl[F_INV], 1'b1};
      if (!trap)
        rf[t] = r;
      @(posedge clk_i);
      go  <= 1'b1;
      fld <= {lng, f, s, t};
      cop <= uc;
      fr  <= fm;
      @(posedge clk_i);
      go <= i[2];
      @(posedge clk_i);
      go <= 1'b0;
      #1;
      chk({busy, done}, 2'b10);
      @(posedge clk_i);
      #1;
      chk({busy, done, exc, exc_code}, {2'b01, trap, code});
      if (!trap)
        chk(result, r);
      repeat (2)
      begin
        @(posedge clk_i);
        #1;
        chk(done, 1'b0);
      end
      rd(ADDR_CTRL, d);
      chk(d, {12'h0, cause, 4'h0, en, 4'h0, flags});
      rd(ADDR_IST, d);
      chk(d, {29'h0, ist});
      chk(irq, (ist & imask) != 3'h0);
      if (!trap)
      begin
        rd(ADDR_RES_HI, d);
        chk(d, r[63:32]);
      end
      $display("Test op %0d done", i);
    end
    wrap_up();
  end
endmodule
